// *** logic/ptc_pkg.sv ***
// register map, field layout and mode codes of the periodic timer
// assumes a 32-bit AXI4-Lite bus, one 8-bit register per aligned word
package ptc_pkg;

   // byte addresses of the registers
   localparam logic [7:0] OFS_TIMER_CONTROL_ONE = 8'h00;
   localparam logic [7:0] OFS_CAPTURE_CLEAR     = 8'h04;
   localparam logic [7:0] OFS_COUNTER_LOW       = 8'h08;
   localparam logic [7:0] OFS_COUNTER_HIGH      = 8'h0C;
   localparam logic [7:0] OFS_COMPARE_A_LOW     = 8'h10;
   localparam logic [7:0] OFS_COMPARE_A_HIGH    = 8'h14;
   localparam logic [7:0] OFS_COMPARE_B_LOW     = 8'h18;
   localparam logic [7:0] OFS_COMPARE_B_HIGH    = 8'h1C;
   localparam logic [7:0] OFS_PERIOD_LOW        = 8'h20;
   localparam logic [7:0] OFS_PERIOD_HIGH       = 8'h24;
   localparam logic [7:0] OFS_RUN_CONTROL       = 8'h28;
   localparam logic [7:0] OFS_MATCH_STATUS      = 8'h2C;

   // field positions outside the control byte
   localparam int unsigned POS_COUNTER_ON  = 0;
   localparam int unsigned POS_FLAG_A      = 0;
   localparam int unsigned POS_FLAG_P      = 1;
   localparam int unsigned POS_LATCH_EDGE  = 0;
   localparam int unsigned POS_CAP_CLR_LSB = 1;

   // reset values and the counter maximum
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // mode select codes
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM     = 2'h2;
   localparam logic [1:0] MODE_TIMER   = 2'h3;

   // pin action codes (compare / pwm / capture meaning share the codes)
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_LOW    = 2'h1;
   localparam logic [1:0] ACT_HIGH   = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // timer control one byte, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] mode_select;
      logic [1:0] pin_action_select;
      logic       output_level_control;
      logic       output_invert;
      logic       capture_source_select;
      logic       counter_clear_select;
   } ptc_ctrl_type;

endpackage : ptc_pkg

// *** logic/ptc_timer.sv ***
// periodic timer compare unit with its AXI4-Lite register slave
// assumes count_tick is a one-cycle pulse from an outside prescaler and
// that all pins are already synchronous to aclk
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Operation
// R1: compare mode A match drives pin low, high or toggles; zero leaves it.
// R2: a requested level equal to the initial level changes nothing visible.
// R3: counter_on rising edge returns the pin to its initial level.
// R4: software changes pin action in pwm mode only with the timer off.
// R5: output level control sets initial level, or pwm active polarity.
// R6: single pulse level set on counter_on rise; no effect in timer mode.
// R7: output invert flips the pin; no effect in timer/counter mode.
// R8: capture source select picks capture pin (0) or timer clock pin (1).
// R9: clear select 1 clears on A match; 0 on P match or overflow.
// R10: overflow clears the counter only when the period value is zero.
// R11: clear select is ignored in pwm, single pulse and capture modes.
// R12: capture clear select adds rising, falling or both edges to P match.
// R13: latch edge flag reads 1 after rising-edge latch, 0 after falling.
// R14: counter readable as low and high read-only bytes, reset zero.
// R15: compare A, B and period are 16-bit byte pairs, reset zero.
// R16: compare mode, clear select 0: clear on P or overflow, raise flags.
// R17: clear select 1: clear on A match, never raise the P flag.
// R18: compare A zero: counter overflows at FFFF, no A flag.
// R19: only A match moves the pin in compare mode; P match does not.
// R20: upper five bits of capture clear register read zero.
// R21: mode select picks compare, capture, pwm/single pulse or timer.
// R22: counter_on rise zeroes the counter; fall holds the count.
// R23: match flags stay set until cleared and drive request outputs.
module ptc_timer
   import ptc_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
) (
   // clock, reset, freeze
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              clk_en,
   // axi4-lite write address and data
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   // axi4-lite write response
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // axi4-lite read
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // timer pins and count tick
   input  wire logic              count_tick,
   input  wire logic              capture_input_pin,
   input  wire logic              external_timer_clock_pin,
   output logic                   timer_output_pin,
   // match request outputs
   output logic                   match_a_flag,
   output logic                   match_p_flag
);

   // register state
   ptc_ctrl_type      ctrl_q;
   logic [1:0]        cap_clr_q;
   logic              latch_edge_q;
   logic [15:0]       counter_q;
   logic [15:0]       cmp_a_q;
   logic [15:0]       cmp_b_q;
   logic [15:0]       period_q;
   logic              counter_on_q;
   logic              on_prev_q;
   logic              src_prev_q;
   logic              pin_q;
   logic              pin_d;
   logic              out_q;
   logic              flag_a_q;
   logic              flag_p_q;

   // bus state
   logic              awready_q;
   logic              wready_q;
   logic              aw_have_q;
   logic              w_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0]        w_byte_q;
   logic              w_lane0_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;

   // word-aligned address within the map
   function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = 8'(a);
      return {w[7:2], 2'h0};
   endfunction : word_ofs

   // true for any address the map holds
   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      w = word_ofs(a);
      return (a[ADDR_W-1:0] >> 8) == '0 && w <= OFS_MATCH_STATUS;
   endfunction : addr_known

   // edge selection shared by capture trigger and capture clear
   function automatic logic edge_pick(input logic [1:0] code,
                                      input logic rise,
                                      input logic fall);
      case (code)
         2'h0:    return rise;
         2'h1:    return fall;
         2'h2:    return rise | fall;
         default: return 1'b0;
      endcase
   endfunction : edge_pick

   // register write strobes
   logic       wr_go;
   logic [7:0] wr_ofs;
   assign wr_go  = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_ofs = word_ofs(aw_addr_q);

   function automatic logic wr_hit(input logic [7:0] ofs, input logic go,
                                   input logic lane,
                                   input logic [7:0] at);
      return go & lane & (ofs == at);
   endfunction : wr_hit

   // event decode
   logic on_rise;
   logic running;
   logic cap_src;
   logic src_rise;
   logic src_fall;
   logic at_a;
   logic at_p;
   logic at_max;
   logic clr_evt;
   logic set_a;
   logic set_p;
   logic cap_hit;
   logic pulse_stop;

   assign on_rise  = counter_on_q & ~on_prev_q;                   // R22
   assign running  = counter_on_q & count_tick;
   assign cap_src  = ctrl_q.capture_source_select
                     ? external_timer_clock_pin : capture_input_pin; // R8
   assign src_rise = cap_src & ~src_prev_q;
   assign src_fall = ~cap_src & src_prev_q;
   assign at_max   = running & (counter_q == COUNT_MAX);
   // a zero compare A never matches, so the counter runs to FFFF
   assign at_a     = running & (cmp_a_q != RST_WORD)
                     & (counter_q == cmp_a_q);                     // R18
   // a zero period makes overflow stand in for the P match
   assign at_p     = (period_q == RST_WORD) ? at_max
                     : running & (counter_q == period_q);         // R10

   // clearing sources and flag raising per mode
   always_comb begin
      clr_evt    = 1'b0;
      set_a      = 1'b0;
      set_p      = 1'b0;
      cap_hit    = 1'b0;
      pulse_stop = 1'b0;
      case (ctrl_q.mode_select)                                    // R21
         MODE_COMPARE, MODE_TIMER: begin
            set_a = at_a;
            if (ctrl_q.counter_clear_select) begin                 // R9
               clr_evt = at_a | ((cmp_a_q == RST_WORD) & at_max); // R17
            end else begin
               clr_evt = at_p;                                     // R16
               set_p   = at_p;                                     // R16
            end
         end
         MODE_CAPTURE: begin
            // clear select ignored; edges may add to the P clear
            cap_hit = counter_on_q
                      & edge_pick(ctrl_q.pin_action_select,
                                  src_rise, src_fall);
            clr_evt = at_p | (counter_on_q & (cap_clr_q != 2'h0)
                      & edge_pick(cap_clr_q - 2'h1,
                                  src_rise, src_fall));            // R12
            set_a   = cap_hit;
            set_p   = at_p;
         end
         MODE_PWM: begin
            set_a = at_a;
            if (ctrl_q.pin_action_select == ACT_TOGGLE) begin
               pulse_stop = at_a;                                  // R11
            end else begin
               clr_evt = at_p;                                     // R11
               set_p   = at_p;
            end
         end
         default: begin
            clr_evt = 1'b0;
         end
      endcase
   end

   // counter: restart on enable rise, hold when off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_q <= RST_WORD;                                    // R14
      end else if (clk_en) begin
         if (on_rise) begin
            counter_q <= RST_WORD;                                 // R22
         end else if (clr_evt) begin
            counter_q <= RST_WORD;
         end else if (running) begin
            counter_q <= counter_q + 16'h0001;
         end
      end
   end

   // edge history for counter_on and capture source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_prev_q  <= 1'b0;
         src_prev_q <= 1'b0;
      end else if (clk_en) begin
         on_prev_q  <= counter_on_q;
         src_prev_q <= cap_src;
      end
   end

   // run control; a single pulse ends itself on the A match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_on_q <= 1'b0;
      end else if (clk_en) begin
         if (pulse_stop) begin
            counter_on_q <= 1'b0;
         end else if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_RUN_CONTROL)) begin
            counter_on_q <= w_byte_q[POS_COUNTER_ON];
         end
      end
   end

   // control bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q    <= ptc_ctrl_type'(RST_BYTE);
         cap_clr_q <= 2'h0;
      end else if (clk_en) begin
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_TIMER_CONTROL_ONE)) begin
            ctrl_q <= ptc_ctrl_type'(w_byte_q);
         end
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_CAPTURE_CLEAR)) begin
            cap_clr_q <= w_byte_q[POS_CAP_CLR_LSB +: 2];
         end
      end
   end

   // compare values; a capture overrides a bus write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_q  <= RST_WORD;                                     // R15
         cmp_b_q  <= RST_WORD;
         period_q <= RST_WORD;
      end else if (clk_en) begin
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_COMPARE_A_LOW))
            cmp_a_q[7:0] <= w_byte_q;
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_COMPARE_A_HIGH))
            cmp_a_q[15:8] <= w_byte_q;
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_COMPARE_B_LOW))
            cmp_b_q[7:0] <= w_byte_q;
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_COMPARE_B_HIGH))
            cmp_b_q[15:8] <= w_byte_q;
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_PERIOD_LOW))
            period_q[7:0] <= w_byte_q;
         if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_PERIOD_HIGH))
            period_q[15:8] <= w_byte_q;
         // latch target: A when no edge clearing, B otherwise
         if (cap_hit) begin
            if (cap_clr_q == 2'h0) begin
               cmp_a_q <= counter_q;
            end else begin
               cmp_b_q <= counter_q;
            end
         end
      end
   end

   // latch edge flag records which edge did the last latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_edge_q <= 1'b0;
      end else if (clk_en) begin
         if (cap_hit) begin
            latch_edge_q <= src_rise;                              // R13
         end
      end
   end

   // sticky match flags, a new event beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else if (clk_en) begin
         if (set_a) begin
            flag_a_q <= 1'b1;                                      // R23
         end else if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_MATCH_STATUS)
                      && w_byte_q[POS_FLAG_A]) begin
            flag_a_q <= 1'b0;
         end
         if (set_p) begin
            flag_p_q <= 1'b1;                                      // R23
         end else if (wr_hit(wr_ofs, wr_go, w_lane0_q, OFS_MATCH_STATUS)
                      && w_byte_q[POS_FLAG_P]) begin
            flag_p_q <= 1'b0;
         end
      end
   end

   // pin level before inversion
   always_comb begin
      pin_d = pin_q;
      case (ctrl_q.mode_select)
         MODE_COMPARE: begin
            if (on_rise) begin
               pin_d = ctrl_q.output_level_control;                // R3
            end else if (at_a) begin                               // R19
               case (ctrl_q.pin_action_select)                     // R1
                  ACT_LOW:    pin_d = 1'b0;                        // R2
                  ACT_HIGH:   pin_d = 1'b1;                        // R2
                  ACT_TOGGLE: pin_d = ~pin_q;
                  default:    pin_d = pin_q;
               endcase
            end
         end
         MODE_PWM: begin
            // action codes here: inactive, active, pwm, single pulse
            case (ctrl_q.pin_action_select)                        // R4
               2'h0:    pin_d = ~ctrl_q.output_level_control;      // R5
               2'h1:    pin_d = ctrl_q.output_level_control;
               2'h2:    pin_d = (counter_q < cmp_a_q)
                                ? ctrl_q.output_level_control
                                : ~ctrl_q.output_level_control;
               default: pin_d = counter_on_q & ~pulse_stop
                                ? ctrl_q.output_level_control
                                : ~ctrl_q.output_level_control;    // R6
            endcase
         end
         default: begin
            pin_d = pin_q;
         end
      endcase
   end

   // pin register and output stage; timer mode leaves the pin low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= 1'b0;
         out_q <= 1'b0;
      end else if (clk_en) begin
         pin_q <= pin_d;
         if (ctrl_q.mode_select == MODE_TIMER) begin
            out_q <= 1'b0;                                         // R6
         end else begin
            out_q <= pin_d ^ ctrl_q.output_invert;                 // R7
         end
      end
   end

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= '0;
         w_byte_q  <= RST_BYTE;
         w_lane0_q <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else if (clk_en) begin
         if (awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready_q) begin
            w_have_q  <= 1'b1;
            wready_q  <= 1'b0;
            w_byte_q  <= wdata[7:0];
            w_lane0_q <= wstrb[0];
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // read data view of the map
   logic [7:0] rd_byte;
   always_comb begin
      case (word_ofs(araddr))
         OFS_TIMER_CONTROL_ONE: rd_byte = ctrl_q;
         OFS_CAPTURE_CLEAR:     rd_byte = {5'h00, cap_clr_q,
                                           latch_edge_q};          // R20
         OFS_COUNTER_LOW:       rd_byte = counter_q[7:0];          // R14
         OFS_COUNTER_HIGH:      rd_byte = counter_q[15:8];
         OFS_COMPARE_A_LOW:     rd_byte = cmp_a_q[7:0];
         OFS_COMPARE_A_HIGH:    rd_byte = cmp_a_q[15:8];
         OFS_COMPARE_B_LOW:     rd_byte = cmp_b_q[7:0];
         OFS_COMPARE_B_HIGH:    rd_byte = cmp_b_q[15:8];
         OFS_PERIOD_LOW:        rd_byte = period_q[7:0];
         OFS_PERIOD_HIGH:       rd_byte = period_q[15:8];
         OFS_RUN_CONTROL:       rd_byte = {7'h00, counter_on_q};
         OFS_MATCH_STATUS:      rd_byte = {6'h00, flag_p_q, flag_a_q};
         default:               rd_byte = RST_BYTE;
      endcase
   end

   // read channel: one read at a time, data one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= RESP_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000,
                          addr_known(araddr) ? rd_byte : RST_BYTE};
            rresp_q   <= addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // outputs straight from flops
   assign awready          = awready_q;
   assign wready           = wready_q;
   assign bvalid           = bvalid_q;
   assign bresp            = bresp_q;
   assign arready          = arready_q;
   assign rvalid           = rvalid_q;
   assign rdata            = rdata_q;
   assign rresp            = rresp_q;
   assign timer_output_pin = out_q;
   assign match_a_flag     = flag_a_q;
   assign match_p_flag     = flag_p_q;

endmodule : ptc_timer

// *** testbench/ptc_timer_sva.sv ***
// assertions on the ptc_timer ports: bus answers, flag and pin causes
// assumes one clock domain; bound to every ptc_timer instance
`timescale 1ns/1ps
module ptc_timer_sva
   import ptc_pkg::*;
(
   // clock, reset and bus handshakes
   input wire logic        aclk, aresetn, clk_en, awvalid, awready,
   input wire logic        wvalid, wready, bvalid, bready, arvalid,
   input wire logic        arready, rvalid, rready,
   input wire logic [7:0]  araddr,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   // timer side
   input wire logic        count_tick, timer_output_pin,
   input wire logic        match_a_flag, match_p_flag
);
   // a low clock enable freezes every flop, so it gates the checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);

   // write taken whole, then the response two cycles on
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_answer;
      !awready && !bvalid ##1 bvalid;
   endsequence

   AST_WR_ANSWER: assert property (s_wr_take |=> s_wr_answer)
      else $error("late write response");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
      else $error("late read data");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed early");
   AST_UNMAPPED: assert property (arvalid && arready && araddr > 8'h2F
      |=> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_CAP_CLR_TOP: assert property (arvalid && arready && araddr ==
      OFS_CAPTURE_CLEAR |=> rdata[31:3] == 29'h0)
      else $error("capture clear upper bits not zero");
   AST_FLAG_A_HOLD: assert property ($fell(match_a_flag) |->
      $rose(bvalid))
      else $error("a flag fell without a write");
   AST_FLAG_P_HOLD: assert property ($fell(match_p_flag) |->
      $rose(bvalid))
      else $error("p flag fell without a write");
   // the pin only moves after a count tick or after a register write
   AST_PIN_CAUSE: assert property ($changed(timer_output_pin) |->
      $past(count_tick) || bvalid || $past(bvalid) || $past(bvalid, 2))
      else $error("pin moved without cause");
endmodule : ptc_timer_sva

bind ptc_timer ptc_timer_sva u_sva (.*);

// *** testbench/tb_top.sv ***
// bench for ptc_timer: register map, compare mode, clearing, overflow
// assumes the bench owns every port; ports meet the dut by name
`timescale 1ns/1ps
module tb_top;
   import ptc_pkg::*;
   // bus and pin drives, idle at time zero
   logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, count_tick = 1'b0;
   logic        capture_input_pin = 1'b0, external_timer_clock_pin = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [2:0]  awprot = 3'h0, arprot = 3'h0;
   logic [3:0]  wstrb = 4'hF;
   logic [31:0] wdata = 32'h0;
   // dut outputs
   logic        awready, wready, bvalid, arready, rvalid;
   logic        timer_output_pin, match_a_flag, match_p_flag;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   // model: register bytes by word index, counter, pin level
   int m [12];
   int cnt, pl, n_fail, n_checks, k;

   ptc_timer DUT (.*);

   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] e, s);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic tmo(input int i);
      if (i >= 40) begin
         n_fail++;
         finish_test();
      end
   endtask : tmo

   // model side effects of a write; read-only places ignore it
   function automatic void upd(input int a, input int d);
      case (a)
         8'h04: m[1] = d & 8'h06;
         8'h08, 8'h0C: ;
         8'h28: begin
            if (d[0] && m[10] == 0) begin
               cnt = 0;
               pl = m[0][3];
            end
            m[10] = d & 1;
         end
         8'h2C: m[11] = m[11] & ~d & 3;
         default: m[a / 4] = d;
      endcase
   endfunction : upd

   function automatic int ev(input int i);
      if (i == 2)
         return cnt & 8'hFF;
      if (i == 3)
         return cnt >> 8;
      return i > 11 ? 0 : m[i];
   endfunction : ev

   // pin is forced low in timer mode, else level xor invert
   function automatic int pin_m();
      return m[0][7:6] == 3 ? 0 : pl ^ m[0][2];
   endfunction : pin_m

   // one counted tick: compare on the current value, then clear or count
   function automatic void step();
      int a, p;
      bit ha, hp;
      if (m[10] == 0)
         return;
      a = m[5] * 256 + m[4];
      p = m[9] * 256 + m[8];
      ha = a != 0 && cnt == a;
      hp = !m[0][0] && (p != 0 ? cnt == p : cnt == 16'hFFFF);
      if (ha && m[0][5:4] != 0)
         pl = m[0][5:4] == 3 ? !pl : m[0][5:4] - 1;
      m[11] = m[11] | ha | (hp << 1);
      cnt = (m[0][0] ? ha : hp) ? 0 : (cnt + 1) & 16'hFFFF;
   endfunction : step

   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int i;
      logic ah, wh, bh;
      logic [1:0] r;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge aclk);
         ah = awready;
         wh = wready;
         bh = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ah)
            awvalid <= 1'b0;
         if (wh)
            wvalid <= 1'b0;
         if (bh)
            break;
      end
      bready <= 1'b0;
      tmo(i);
      chk("bresp", a > 8'h2C ? RESP_SLVERR : RESP_OKAY, r);
      upd(a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int i;
      logic ah, rh;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge aclk);
         ah = arready;
         rh = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ah)
            arvalid <= 1'b0;
         if (rh)
            break;
      end
      rready <= 1'b0;
      tmo(i);
      chk("rdata", ev(a / 4), d);
      chk("rresp", a > 8'h2C ? RESP_SLVERR : RESP_OKAY, r);
   endtask : rd

   // tick held high for n edges, one model step per edge
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge aclk);
         count_tick <= 1'b1;
         step();
      end
      @(posedge aclk);
      count_tick <= 1'b0;
   endtask : tick

   task automatic pin_chk(input string nm);
      @(negedge aclk);
      chk(nm, pin_m(), timer_output_pin);
      chk("flags", m[11], {match_p_flag, match_a_flag});
   endtask : pin_chk

   // main sequence
   initial begin
      void'($urandom(32'h264D1788));
      capture_input_pin <= 1'($urandom);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 13; k++)
         rd(k * 4);
      for (k = 1; k < 10; k++) begin
         wr(k * 4, $urandom);
         rd(k * 4);
      end
      // compare a at 2, period 3: every action against both levels
      wr(8'h14, 0);
      wr(8'h24, 0);
      wr(8'h10, 2);
      wr(8'h20, 3);
      for (k = 0; k < 8; k++) begin
         wr(8'h28, 0);
         wr(8'h00, 8'(k * 8 + ($urandom & 4)));
         wr(8'h28, 1);
         pin_chk("pin initial");
         tick(3);
         pin_chk("pin a match");
         tick(1);
         pin_chk("pin p match");
         rd(8'h08);
         rd(8'h2C);
         wr(8'h2C, 3);
         rd(8'h2C);
      end
      // clear on compare a with a period below it: no p flag
      wr(8'h20, 1);
      wr(8'h00, 8'h01);
      wr(8'h28, 0);
      wr(8'h28, 1);
      tick(5);
      rd(8'h08);
      rd(8'h2C);
      wr(8'h00, 8'hC4);
      pin_chk("pin timer mode");
      // period and compare a zero: the wrap is the only clear
      wr(8'h00, 8'h00);
      wr(8'h10, 0);
      wr(8'h20, 0);
      wr(8'h2C, 3);
      wr(8'h28, 0);
      wr(8'h28, 1);
      tick(65536);
      rd(8'h08);
      rd(8'h0C);
      rd(8'h2C);
      finish_test();
   end
endmodule : tb_top
